// *** src/palette_pkg.sv ***
// Shared constants and carrier types for the palette access port.
// Assumes a 10-bit host I/O port address space.
package palette_pkg;
  localparam logic [9:0] pixel_mask_addr = 10'h3c6;
  localparam logic [9:0] read_pointer_addr = 10'h3c7;
  localparam logic [9:0] cycle_state_addr = 10'h3c7;
  localparam logic [9:0] write_pointer_addr = 10'h3c8;
  localparam logic [9:0] data_port_addr = 10'h3c9;
  localparam int gio_enable_bit = 2;
  localparam logic [1:0] state_after_write = 2'h0;
  localparam logic [1:0] state_after_read = 2'h3;
  localparam logic [7:0] pixel_mask_rst = 8'hff;
  localparam logic [7:0] pointer_rst = 8'h00;
  localparam int lut_depth = 256;

  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
  } colour_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } io_req_t;

  typedef enum logic [1:0] {
    pos_red,
    pos_green,
    pos_blue
  } byte_pos_t;
endpackage

// *** src/palette_ram.sv ***
// Colour look-up table storage, one write port and two read ports.
// Assumes a single clock; read ports are combinational.
`timescale 1ns/100ps
`default_nettype none
module palette_ram (
  // Clock
  input wire logic ref_clk,
  // Host write port
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire palette_pkg::colour_t wdata,
  // Host read port
  input wire logic [7:0] raddr,
  output palette_pkg::colour_t rdata,
  // Pixel read port
  input wire logic [7:0] paddr,
  output palette_pkg::colour_t pdata
);
  import palette_pkg::*;

  colour_t mem [lut_depth];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
  assign pdata = mem[paddr];
endmodule
`default_nettype wire

// *** src/pixel_lookup.sv ***
// Masked pixel look-up: mask the select, register the colour out.
// Assumes the table read port answers combinationally.
`timescale 1ns/100ps
`default_nettype none
module pixel_lookup (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pixel path
  input wire logic [7:0] pixel_select_bus,
  input wire logic [7:0] mask,
  output logic [7:0] table_index,
  input wire palette_pkg::colour_t table_data,
  output palette_pkg::colour_t pixel_colour_q
);
  import palette_pkg::*;

  assign table_index = pixel_select_bus & mask;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pixel_colour_q <= '0;
    end else begin
      pixel_colour_q <= table_data;
    end
  end
endmodule
`default_nettype wire

// *** src/palette_lut_access_port.sv ***
// Host access logic for the 256-entry colour table and pixel mask.
// Assumes one host I/O access per strobe, synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module palette_lut_access_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Host I/O port
  input wire palette_pkg::io_req_t io_req,
  output logic [7:0] io_rdata_q,
  output logic io_rvalid_q,
  // Control bits from the extended registers
  input wire logic palette_write_lock,
  input wire logic [7:0] extended_palette_control,
  // External lines
  input wire logic [7:0] general_io_lines,
  input wire logic [7:0] pixel_select_bus,
  output palette_pkg::colour_t pixel_colour_q
);
  import palette_pkg::*;

  logic [7:0] pixel_mask_q;
  logic [7:0] read_ptr_q;
  logic [7:0] write_ptr_q;
  logic [1:0] cycle_state_q;
  byte_pos_t rd_pos_q;
  byte_pos_t wr_pos_q;
  colour_t rd_hold_q;
  colour_t wr_hold_q;
  logic fetch_q;
  logic [7:0] table_index;
  colour_t table_rdata;
  colour_t pixel_data;
  logic [7:0] rdata_d;

  // Decoded strobes; lock gates every write into the palette registers
  logic wr_ok;
  logic wr_mask;
  logic wr_rptr;
  logic wr_wptr;
  logic wr_data;
  logic rd_data;
  logic store;
  logic [7:0] store_ptr;

  assign wr_ok = io_req.wr & ~palette_write_lock;
  assign wr_mask = wr_ok & (io_req.addr == pixel_mask_addr);
  assign wr_rptr = wr_ok & (io_req.addr == read_pointer_addr);
  assign wr_wptr = wr_ok & (io_req.addr == write_pointer_addr);
  assign wr_data = wr_ok & (io_req.addr == data_port_addr);
  assign rd_data = io_req.rd & (io_req.addr == data_port_addr);
  assign store = wr_data & (wr_pos_q == pos_blue);
  assign store_ptr = write_ptr_q;

  palette_ram u_ram (
    .ref_clk(ref_clk),
    .we(store),
    .waddr(store_ptr),
    .wdata({wr_hold_q.red, wr_hold_q.green, io_req.wdata[5:0]}),
    .raddr(read_ptr_q),
    .rdata(table_rdata),
    .paddr(table_index),
    .pdata(pixel_data)
  );

  pixel_lookup u_pix (
    .ref_clk(ref_clk),
    .rst(rst),
    .pixel_select_bus(pixel_select_bus),
    .mask(pixel_mask_q),
    .table_index(table_index),
    .table_data(pixel_data),
    .pixel_colour_q(pixel_colour_q)
  );

  // Mask is independent of the palette sequencers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pixel_mask_q <= pixel_mask_rst;
    end else if (wr_mask) begin
      pixel_mask_q <= io_req.wdata;
    end
  end

  // Read pointer and byte position
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      read_ptr_q <= pointer_rst;
      rd_pos_q <= pos_red;
    end else if (wr_rptr) begin
      read_ptr_q <= io_req.wdata;
      rd_pos_q <= pos_red;
    end else if (rd_data) begin
      case (rd_pos_q)
        pos_red: rd_pos_q <= pos_green;
        pos_green: rd_pos_q <= pos_blue;
        pos_blue: begin
          rd_pos_q <= pos_red;
          read_ptr_q <= read_ptr_q + 8'h01;
        end
        default: rd_pos_q <= pos_red;
      endcase
    end
  end

  // Fetch one cycle after the pointer settles, so the table is read at
  // the new pointer rather than the old one.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fetch_q <= 1'b0;
    end else begin
      fetch_q <= wr_rptr | (rd_data & (rd_pos_q == pos_blue));
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_hold_q <= '0;
    end else if (fetch_q) begin
      rd_hold_q <= table_rdata;
    end
  end

  // Write pointer, byte position and holding value
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      write_ptr_q <= pointer_rst;
      wr_pos_q <= pos_red;
      wr_hold_q <= '0;
    end else if (wr_wptr) begin
      write_ptr_q <= io_req.wdata;
      wr_pos_q <= pos_red;
    end else if (wr_data) begin
      case (wr_pos_q)
        pos_red: begin
          wr_hold_q.red <= io_req.wdata[5:0];
          wr_pos_q <= pos_green;
        end
        pos_green: begin
          wr_hold_q.green <= io_req.wdata[5:0];
          wr_pos_q <= pos_blue;
        end
        pos_blue: begin
          wr_hold_q.blue <= io_req.wdata[5:0];
          wr_pos_q <= pos_red;
          write_ptr_q <= write_ptr_q + 8'h01;
        end
        default: wr_pos_q <= pos_red;
      endcase
    end
  end

  // Last palette cycle type
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cycle_state_q <= state_after_write;
    end else if (wr_rptr | rd_data) begin
      cycle_state_q <= state_after_read;
    end else if (wr_wptr | wr_data) begin
      cycle_state_q <= state_after_write;
    end
  end

  // Read mux; pointer and status reads touch no sequencer state
  always_comb begin
    rdata_d = 8'h00;
    case (io_req.addr)
      pixel_mask_addr: rdata_d = pixel_mask_q;
      cycle_state_addr: rdata_d = {6'h00, cycle_state_q};
      write_pointer_addr: begin
        if (extended_palette_control[gio_enable_bit]) begin
          rdata_d = general_io_lines;
        end else begin
          rdata_d = write_ptr_q;
        end
      end
      data_port_addr: begin
        case (rd_pos_q)
          pos_red: rdata_d = {2'h0, rd_hold_q.red};
          pos_green: rdata_d = {2'h0, rd_hold_q.green};
          pos_blue: rdata_d = {2'h0, rd_hold_q.blue};
          default: rdata_d = 8'h00;
        endcase
      end
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      io_rdata_q <= 8'h00;
      io_rvalid_q <= 1'b0;
    end else begin
      io_rvalid_q <= io_req.rd;
      if (io_req.rd) begin
        io_rdata_q <= rdata_d;
      end
    end
  end

  property p_mask_index;
    @(posedge ref_clk) disable iff (rst)
    table_index == (pixel_select_bus & pixel_mask_q);
  endproperty
  a_mask_index: assert property (p_mask_index)
    else $error("pixel index not masked");

  property p_mask_write;
    @(posedge ref_clk) disable iff (rst)
    wr_mask |=> pixel_mask_q == $past(io_req.wdata);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write lost");

  property p_rptr_load;
    @(posedge ref_clk) disable iff (rst)
    wr_rptr |=> read_ptr_q == $past(io_req.wdata) && rd_pos_q == pos_red;
  endproperty
  a_rptr_load: assert property (p_rptr_load)
    else $error("read pointer load wrong");

  property p_rd_fetch;
    @(posedge ref_clk) disable iff (rst)
    wr_rptr ##1 !wr_rptr |=> rd_hold_q == $past(table_rdata);
  endproperty
  a_rd_fetch: assert property (p_rd_fetch)
    else $error("entry not fetched");

  property p_rd_upper;
    @(posedge ref_clk) disable iff (rst)
    io_rvalid_q && $past(rd_data) |-> io_rdata_q[7:6] == 2'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("palette read upper bits set");

  property p_rd_incr;
    @(posedge ref_clk) disable iff (rst)
    rd_data && !wr_rptr && rd_pos_q == pos_blue |=> read_ptr_q == $past(read_ptr_q) + 8'h01;
  endproperty
  a_rd_incr: assert property (p_rd_incr)
    else $error("read pointer no increment");

  property p_wr_incr;
    @(posedge ref_clk) disable iff (rst)
    store && !wr_wptr |=> write_ptr_q == $past(write_ptr_q) + 8'h01;
  endproperty
  a_wr_incr: assert property (p_wr_incr)
    else $error("write pointer no increment");

  property p_lock;
    @(posedge ref_clk) disable iff (rst)
    palette_write_lock |=> $stable(write_ptr_q) && $stable(pixel_mask_q);
  endproperty
  a_lock: assert property (p_lock)
    else $error("write accepted while locked");

  property p_status;
    @(posedge ref_clk) disable iff (rst)
    wr_wptr |=> cycle_state_q == state_after_write;
  endproperty
  a_status: assert property (p_status)
    else $error("status not write cycle");

  property p_wptr_load;
    @(posedge ref_clk) disable iff (rst)
    wr_wptr |=> write_ptr_q == $past(io_req.wdata) && wr_pos_q == pos_red;
  endproperty
  a_wptr_load: assert property (p_wptr_load)
    else $error("write pointer load wrong");

  property p_wr_red;
    @(posedge ref_clk) disable iff (rst)
    wr_data && wr_pos_q == pos_red |=> wr_hold_q.red == $past(io_req.wdata[5:0]) && wr_pos_q == pos_green;
  endproperty
  a_wr_red: assert property (p_wr_red)
    else $error("red byte not held");

  property p_wr_green;
    @(posedge ref_clk) disable iff (rst)
    wr_data && wr_pos_q == pos_green |=> wr_hold_q.green == $past(io_req.wdata[5:0]) && wr_pos_q == pos_blue;
  endproperty
  a_wr_green: assert property (p_wr_green)
    else $error("green byte not held");

  property p_wr_wrap;
    @(posedge ref_clk) disable iff (rst)
    store |=> wr_pos_q == pos_red && wr_hold_q.blue == $past(io_req.wdata[5:0]);
  endproperty
  a_wr_wrap: assert property (p_wr_wrap)
    else $error("write group not closed");

  property p_rd_status;
    @(posedge ref_clk) disable iff (rst)
    rd_data |=> cycle_state_q == state_after_read;
  endproperty
  a_rd_status: assert property (p_rd_status)
    else $error("status not read cycle");

  property p_status_value;
    @(posedge ref_clk) disable iff (rst)
    io_req.rd && io_req.addr == cycle_state_addr |=> io_rdata_q == {6'h00, $past(cycle_state_q)};
  endproperty
  a_status_value: assert property (p_status_value)
    else $error("status read wrong");

  property p_quiet_read;
    @(posedge ref_clk) disable iff (rst)
    io_req.rd && !io_req.wr && io_req.addr != data_port_addr |=>
      $stable(rd_pos_q) && $stable(wr_pos_q) && $stable(read_ptr_q) && $stable(write_ptr_q);
  endproperty
  a_quiet_read: assert property (p_quiet_read)
    else $error("register read disturbed a sequence");

  property p_gio;
    @(posedge ref_clk) disable iff (rst)
    io_req.rd && io_req.addr == write_pointer_addr && extended_palette_control[gio_enable_bit]
      |=> io_rdata_q == $past(general_io_lines);
  endproperty
  a_gio: assert property (p_gio)
    else $error("general input not returned");

  property p_rd_green;
    @(posedge ref_clk) disable iff (rst)
    rd_data && rd_pos_q == pos_green |=> io_rdata_q == {2'h0, $past(rd_hold_q.green)} && rd_pos_q == pos_blue;
  endproperty
  a_rd_green: assert property (p_rd_green)
    else $error("green byte out of order");

  property p_rvalid;
    @(posedge ref_clk) disable iff (rst)
    io_req.rd |=> io_rvalid_q;
  endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("read not answered");
endmodule
`default_nettype wire

// *** verification/host_io_model.sv ***
// Host CPU model: single-cycle I/O reads and writes on the access port.
// Assumes one calling process; strobes change 1 ns after the clock edge.
`timescale 1ns/100ps
`default_nettype none
module host_io_model (
  // Clock
  input wire logic ref_clk,
  // Host I/O port
  output var palette_pkg::io_req_t io_req
);
  import palette_pkg::*;

  initial io_req = '0;

  // Groups of three are never broken by the other direction
  // No video is shown here, so every access counts as blanked
  task automatic put(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    io_req = '{wr: w, rd: !w, addr: a, wdata: d};
    // Strobe drops after its edge so no access repeats while the bench waits
    @(posedge ref_clk);
    #1;
    io_req.wr = 1'b0;
    io_req.rd = 1'b0;
  endtask

  // Released data lines toggle so a stale byte never looks valid
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      io_req.wr = 1'b0;
      io_req.rd = 1'b0;
      io_req.wdata = ~io_req.wdata;
    end
  endtask
endmodule
`default_nettype wire

// *** verification/palette_lut_access_port_tb_top.sv ***
// Self-checking bench for the palette access port.
// Assumes host_io_model drives the I/O port; reads are scored from a queue.
`timescale 1ns/100ps
`default_nettype none
module palette_lut_access_port_tb_top;
  import palette_pkg::*;
  logic ref_clk = 1'b0;
  logic rst;
  io_req_t io_req;
  logic [7:0] io_rdata_q;
  logic io_rvalid_q;
  logic palette_write_lock;
  logic [7:0] extended_palette_control;
  logic [7:0] general_io_lines;
  logic [7:0] pixel_select_bus;
  colour_t pixel_colour_q;
  colour_t lut [256];
  colour_t c;
  logic [7:0] exp_q [$];
  logic [31:0] seed = 32'd42;
  logic [7:0] mask;
  logic [7:0] b;
  int n_fail = 0;
  int total_checks = 0;

  always #10 ref_clk = ~ref_clk;

  host_io_model u_host (.ref_clk(ref_clk), .io_req(io_req));
  palette_lut_access_port u_dut (.ref_clk(ref_clk), .rst(rst), .io_req(io_req),
    .io_rdata_q(io_rdata_q), .io_rvalid_q(io_rvalid_q),
    .palette_write_lock(palette_write_lock),
    .extended_palette_control(extended_palette_control),
    .general_io_lines(general_io_lines),
    .pixel_select_bus(pixel_select_bus), .pixel_colour_q(pixel_colour_q));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_pix(input colour_t got, input colour_t exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    u_host.put(1'b1, a, d);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.put(1'b0, a, 8'h00);
  endtask

  // Upper two bits random so only the low six may land
  task automatic put_entry(input logic [7:0] idx);
    for (int k = 0; k < 3; k++) begin
      b = rnd();
      c = {c[11:0], b[5:0]};
      wr(data_port_addr, b);
    end
    lut[idx] = c;
  endtask

  task automatic get_entry(input logic [7:0] idx);
    rd(data_port_addr, {2'b00, lut[idx].red});
    rd(data_port_addr, {2'b00, lut[idx].green});
    rd(data_port_addr, {2'b00, lut[idx].blue});
    u_host.idle(1);
  endtask

  task automatic close_out();
    check8(8'(exp_q.size()), 8'h00);
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(negedge ref_clk) begin
    if (io_rvalid_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        check8(io_rdata_q, ~io_rdata_q);
      end else begin
        check8(io_rdata_q, exp_q.pop_front());
      end
    end
  end

  initial begin
    #1_000_000;
    n_fail++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    palette_write_lock = 1'b0;
    // Other control bits random: only the general input enable may matter
    extended_palette_control = rnd() & ~8'(1 << gio_enable_bit);
    general_io_lines = rnd();
    pixel_select_bus = rnd();
    repeat (16) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    rd(cycle_state_addr, {6'h00, state_after_write});
    rd(10'h3c5, 8'h00);
    wr(write_pointer_addr, 8'h00);
    for (int i = 0; i < lut_depth; i++) put_entry(8'(i));
    rd(write_pointer_addr, 8'h00);
    wr(write_pointer_addr, 8'hff);
    wr(data_port_addr, rnd());
    rd(cycle_state_addr, {6'h00, state_after_write});
    wr(write_pointer_addr, 8'hff);
    put_entry(8'hff);
    wr(read_pointer_addr, 8'hfe);
    u_host.idle(2);
    rd(data_port_addr, {2'b00, lut[8'hfe].red});
    rd(cycle_state_addr, {6'h00, state_after_read});
    mask = rnd();
    wr(pixel_mask_addr, mask);
    rd(data_port_addr, {2'b00, lut[8'hfe].green});
    rd(data_port_addr, {2'b00, lut[8'hfe].blue});
    u_host.idle(1);
    get_entry(8'hff);
    get_entry(8'h00);
    wr(read_pointer_addr, 8'h10);
    u_host.idle(2);
    rd(data_port_addr, {2'b00, lut[8'h10].red});
    wr(read_pointer_addr, 8'h20);
    u_host.idle(2);
    get_entry(8'h20);
    rd(pixel_mask_addr, mask);
    for (int i = 0; i < 8; i++) begin
      pixel_select_bus = rnd();
      @(posedge ref_clk);
      #1;
      check_pix(pixel_colour_q, lut[pixel_select_bus & mask]);
    end
    palette_write_lock = 1'b1;
    wr(pixel_mask_addr, ~mask);
    wr(write_pointer_addr, 8'h40);
    wr(read_pointer_addr, 8'h40);
    for (int k = 0; k < 3; k++) wr(data_port_addr, rnd());
    u_host.idle(1);
    palette_write_lock = 1'b0;
    rd(pixel_mask_addr, mask);
    rd(write_pointer_addr, 8'h00);
    wr(read_pointer_addr, 8'h00);
    u_host.idle(2);
    get_entry(8'h00);
    extended_palette_control = extended_palette_control | 8'(1 << gio_enable_bit);
    general_io_lines = rnd();
    rd(write_pointer_addr, general_io_lines);
    u_host.idle(1);
    extended_palette_control = extended_palette_control & ~8'(1 << gio_enable_bit);
    rd(write_pointer_addr, 8'h00);
    u_host.idle(3);
    close_out();
  end
endmodule
`default_nettype wire
